// >>> rtl/scm_consts.vh
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH
// register byte addresses (one aligned word each)
`define SCM_ADDR_CTRL1    12'h000
`define SCM_ADDR_CTRL2    12'h004
`define SCM_ADDR_BAUD     12'h008
`define SCM_ADDR_STATUS   12'h00C
`define SCM_ADDR_DATA     12'h010
`define SCM_ADDR_POWER    12'h014
// control one fields
`define SCM_C1_RX_FAULT_IRQ_EN 7
`define SCM_C1_MODULE_ENABLE   6
`define SCM_C1_TX_EMPTY_IRQ_EN 5
`define SCM_C1_MASTER_SELECT   4
`define SCM_C1_CLOCK_POLARITY  3
`define SCM_C1_CLOCK_PHASE     2
`define SCM_C1_SELECT_OUT_EN   1
`define SCM_C1_LOW_BIT_FIRST   0
// control two fields
`define SCM_C2_FAULT_FN_EN     4
`define SCM_C2_MASK            8'h1B
// status fields
`define SCM_ST_RX_FULL         7
`define SCM_ST_TX_EMPTY        5
`define SCM_ST_FAULT           4
// power register fields
`define SCM_PW_STOP_LIGHT      0
`define SCM_PW_STOP_DEEP       1
// reset values
`define SCM_C1_RESET           8'h04
`define SCM_C2_RESET           8'h00
`define SCM_BR_RESET           8'h00
`define SCM_BR_MASK            8'h77
`endif

// >>> rtl/scm_ctrl.v
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "scm_consts.vh"

module scm_ctrl (
	// system
	input  wire        clk,
	input  wire        rstn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// stop-mode wake request from the system controller
	input  wire        stop_wake_irq,
	// serial pins
	input  wire        sclk_in,
	output reg         sclk_out,
	output reg         sclk_oe,
	input  wire        mosi_in,
	output reg         mosi_out,
	output reg         mosi_oe,
	input  wire        miso_in,
	output reg         miso_out,
	output reg         miso_oe,
	input  wire        sel_in,
	output reg         sel_out,
	output reg         sel_oe,
	// status to system
	output wire        irq,
	output wire        sel_pin_is_gpio
);

	localparam ST_IDLE = 2'd0;
	localparam ST_LEAD = 2'd1;
	localparam ST_SHIFT = 2'd2;

	reg  [7:0] ctrl1_r, ctrl2_r, baud_r, txbuf_r, rxbuf_r, shift_r;
	reg        rx_full_r, tx_empty_r, fault_r, txload_r;
	reg        obit_r, sel_hold_r;
	reg        stop_light_r, stop_deep_r;
	reg  [1:0] state_r;
	reg  [3:0] bit_cnt_r;
	reg  [11:0] div_cnt_r;
	reg        phase_r;
	reg  [2:0] sclk_s, mosi_s, miso_s, sel_s;
	reg        sclk_prev_r;

	// decoded controls
	wire en        = ctrl1_r[`SCM_C1_MODULE_ENABLE] & ~stop_light_r & ~stop_deep_r;
	wire master    = ctrl1_r[`SCM_C1_MASTER_SELECT];
	wire clock_polarity      = ctrl1_r[`SCM_C1_CLOCK_POLARITY];
	wire clock_phase      = ctrl1_r[`SCM_C1_CLOCK_PHASE];
	wire lsbf      = ctrl1_r[`SCM_C1_LOW_BIT_FIRST];
	wire select_output_enable      = ctrl1_r[`SCM_C1_SELECT_OUT_EN];
	wire faulten   = ctrl2_r[`SCM_C2_FAULT_FN_EN];
	wire fault_in  = en & master & faulten & ~select_output_enable;
	wire auto_sel  = en & master & faulten & select_output_enable;
	assign sel_pin_is_gpio = ~en | (master & ~faulten);

	// phase 0 marks the sampling edge in both phases; the other edge drives the next bit
	wire trail_now = phase_r ^ clock_phase;
	wire smp_now   = ~phase_r;
	wire last_edge = trail_now & ((bit_cnt_r == 4'd8) | (smp_now & (bit_cnt_r == 4'd7)));

	// apb: zero wait, unmapped reads as zero with error
	wire acc = psel & penable;
	wire wr  = acc & pwrite;
	wire mapped = (paddr <= `SCM_ADDR_POWER) && (paddr[1:0] == 2'b00);
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	wire wr_c1 = wr & (paddr == `SCM_ADDR_CTRL1);
	wire wr_d  = wr & (paddr == `SCM_ADDR_DATA);
	wire rd_d  = acc & ~pwrite & (paddr == `SCM_ADDR_DATA);

	// interrupt request levels
	assign irq = ~stop_deep_r & ((ctrl1_r[`SCM_C1_RX_FAULT_IRQ_EN] & (rx_full_r | fault_r))
		| (ctrl1_r[`SCM_C1_TX_EMPTY_IRQ_EN] & tx_empty_r));

	// pin synchronisers; edges judged on stages two and three
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_s <= 3'b000;
			mosi_s <= 3'b000;
			miso_s <= 3'b000;
			sel_s  <= 3'b111;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_in};
			mosi_s <= {mosi_s[1:0], mosi_in};
			miso_s <= {miso_s[1:0], miso_in};
			sel_s  <= {sel_s[1:0], sel_in};
		end
	end
	wire sclk_stable = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_prev_r;
	wire sclk_lvl = sclk_stable ^ clock_polarity;
	wire sclk_lead = sclk_lvl & ~(sclk_prev_r ^ clock_polarity);
	wire sclk_trail = ~sclk_lvl & (sclk_prev_r ^ clock_polarity);
	wire sel_low = (sel_s[1] == sel_s[2]) & ~sel_s[2];
	wire din = master ? miso_s[2] : mosi_s[2];

	// master bit rate: prescale (1..8) times divisor (2..256), half period count
	wire [11:0] half_div = ({9'd0, baud_r[6:4]} + 12'd1) << baud_r[2:0];

	// bit order helpers
	function [7:0] scm_shift;
		input [7:0] v;
		input       lsb;
		input       b;
		begin
			scm_shift = lsb ? {b, v[7:1]} : {v[6:0], b};
		end
	endfunction
	function scm_out;
		input [7:0] v;
		input       lsb;
		begin
			scm_out = lsb ? v[0] : v[7];
		end
	endfunction

	// main sequential logic
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl1_r      <= `SCM_C1_RESET;
			ctrl2_r      <= `SCM_C2_RESET;
			baud_r       <= `SCM_BR_RESET;
			txbuf_r      <= 8'h00;
			rxbuf_r      <= 8'h00;
			shift_r      <= 8'h00;
			obit_r       <= 1'b0;
			rx_full_r    <= 1'b0;
			tx_empty_r   <= 1'b1;
			fault_r      <= 1'b0;
			txload_r     <= 1'b0;
			stop_light_r <= 1'b0;
			stop_deep_r  <= 1'b0;
			state_r      <= ST_IDLE;
			bit_cnt_r    <= 4'd0;
			div_cnt_r    <= 12'd0;
			phase_r      <= 1'b0;
			sclk_prev_r  <= 1'b0;
		end else if (stop_deep_r) begin
			// module powered down; comes back in reset state on wake
			ctrl1_r    <= `SCM_C1_RESET;
			ctrl2_r    <= `SCM_C2_RESET;
			baud_r     <= `SCM_BR_RESET;
			txbuf_r    <= 8'h00;
			rxbuf_r    <= 8'h00;
			shift_r    <= 8'h00;
			obit_r     <= 1'b0;
			rx_full_r  <= 1'b0;
			tx_empty_r <= 1'b1;
			fault_r    <= 1'b0;
			txload_r   <= 1'b0;
			state_r    <= ST_IDLE;
			bit_cnt_r  <= 4'd0;
			div_cnt_r  <= 12'd0;
			phase_r    <= 1'b0;
			if (stop_wake_irq)
				stop_deep_r <= 1'b0;
		end else if (stop_light_r) begin
			// clocks halted: everything holds, only wake is watched
			if (stop_wake_irq)
				stop_light_r <= 1'b0;
		end else begin
			sclk_prev_r <= sclk_stable;
			// register writes
			if (wr_c1)
				ctrl1_r <= pwdata[7:0];
			if (wr & (paddr == `SCM_ADDR_CTRL2))
				ctrl2_r <= pwdata[7:0] & `SCM_C2_MASK;
			if (wr & (paddr == `SCM_ADDR_BAUD))
				baud_r <= pwdata[7:0] & `SCM_BR_MASK;
			if (wr & (paddr == `SCM_ADDR_POWER)) begin
				stop_light_r <= pwdata[`SCM_PW_STOP_LIGHT];
				stop_deep_r  <= pwdata[`SCM_PW_STOP_DEEP];
			end
			if (wr_d & en) begin
				txbuf_r    <= pwdata[7:0];
				tx_empty_r <= 1'b0;
				txload_r   <= 1'b1;
			end
			if (rd_d)
				rx_full_r <= 1'b0;
			// fault clears on a status read; a new fault wins
			if (acc & ~pwrite & (paddr == `SCM_ADDR_STATUS))
				fault_r <= 1'b0;
			if (fault_in & sel_low) begin
				fault_r <= 1'b1;
				ctrl1_r[`SCM_C1_MASTER_SELECT] <= 1'b0;
				state_r <= ST_IDLE;
			end
			if (!en) begin
				// disabled: abort, flush buffers, idle the machine
				state_r    <= ST_IDLE;
				txload_r   <= 1'b0;
				bit_cnt_r  <= 4'd0;
				div_cnt_r  <= 12'd0;
				phase_r    <= 1'b0;
				rx_full_r  <= 1'b0;
				tx_empty_r <= 1'b1;
			end else if (!(fault_in & sel_low)) begin
				case (state_r)
				ST_IDLE: begin
					if (txload_r & (master | sel_low)) begin
						shift_r    <= txbuf_r;
						obit_r     <= scm_out(txbuf_r, lsbf);
						txload_r   <= 1'b0;
						tx_empty_r <= ~wr_d;
						bit_cnt_r  <= 4'd0;
						div_cnt_r  <= 12'd0;
						phase_r    <= clock_phase;
						state_r    <= master ? ST_LEAD : ST_SHIFT;
					end
				end
				ST_LEAD: begin
					if (div_cnt_r >= half_div - 12'd1) begin
						div_cnt_r <= 12'd0;
						state_r   <= ST_SHIFT;
					end else
						div_cnt_r <= div_cnt_r + 12'd1;
				end
				ST_SHIFT: begin
					// sample on one edge, drive out on the other, so data never moves as it is taken
					if (master ? (div_cnt_r >= half_div - 12'd1) : (sclk_lead | sclk_trail)) begin
						div_cnt_r <= 12'd0;
						phase_r   <= ~phase_r;
						if (smp_now) begin
							shift_r   <= scm_shift(shift_r, lsbf, din);
							bit_cnt_r <= bit_cnt_r + 4'd1;
						end else
							obit_r <= scm_out(shift_r, lsbf);
						// finish on a trailing edge so the last clock pulse is full length
						if (last_edge) begin
							rxbuf_r   <= smp_now ? scm_shift(shift_r, lsbf, din) : shift_r;
							rx_full_r <= 1'b1;
							state_r   <= ST_IDLE;
						end
					end else if (master)
						div_cnt_r <= div_cnt_r + 12'd1;
					if (!master & ~sel_low)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// register read data
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`SCM_ADDR_CTRL1:  prdata <= {24'h00_0000, ctrl1_r};
			`SCM_ADDR_CTRL2:  prdata <= {24'h00_0000, ctrl2_r};
			`SCM_ADDR_BAUD:   prdata <= {24'h00_0000, baud_r};
			`SCM_ADDR_STATUS: prdata <= {24'h00_0000, rx_full_r, 1'b0, tx_empty_r, fault_r, 4'h0};
			`SCM_ADDR_DATA:   prdata <= {24'h00_0000, rxbuf_r};
			`SCM_ADDR_POWER:  prdata <= {30'h0000_0000, stop_deep_r, stop_light_r};
			default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// pin drivers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_out <= 1'b0;
			sclk_oe  <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe  <= 1'b0;
			miso_out <= 1'b0;
			miso_oe  <= 1'b0;
			sel_out  <= 1'b1;
			sel_oe   <= 1'b0;
			sel_hold_r <= 1'b0;
		end else begin
			sclk_oe  <= en & master;
			sclk_out <= clock_polarity ^ ((state_r == ST_SHIFT) & (phase_r ^ clock_phase));
			mosi_oe  <= en & master;
			mosi_out <= obit_r;
			miso_oe  <= en & ~master & sel_low;
			miso_out <= obit_r;
			sel_oe   <= auto_sel;
			sel_hold_r <= (state_r != ST_IDLE);
			// select lifts one clock after the last edge so the far side still takes it
			sel_out  <= ~(auto_sel & ((state_r != ST_IDLE) | sel_hold_r));
		end
	end

endmodule

// >>> tb/scm_ctrl_asserts.sv
`timescale 1ns/1ps
`include "scm_consts.vh"
module scm_ctrl_asserts (
	// system
	input logic        clk,
	input logic        rstn,
	// apb
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pslverr,
	input logic        stop_wake_irq,
	// pins and status
	input logic        sclk_oe,
	input logic        mosi_oe,
	input logic        miso_oe,
	input logic        sel_oe,
	input logic        irq,
	input logic        sel_pin_is_gpio
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [7:0] c1_r, c2_r;
	logic       pw_r;
	logic [1:0] q_r;
	wire wr = psel & penable & pwrite;
	wire mapped = paddr <= `SCM_ADDR_POWER && paddr[1:0] == 2'b00;
	wire ok = q_r == 2'd3 && !pw_r && c1_r[6];
	wire no_oe = !(sclk_oe | mosi_oe | miso_oe | sel_oe);
	// shadow of written config; settle count hides the design's pipeline
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			c1_r <= 8'h04;
			c2_r <= 8'h00;
			pw_r <= 1'b0;
			q_r  <= 2'd0;
		end else begin
			q_r <= (wr | stop_wake_irq) ? 2'd0 : q_r + {1'b0, q_r != 2'd3};
			if (wr && paddr == `SCM_ADDR_CTRL1) c1_r <= pwdata[7:0];
			if (wr && paddr == `SCM_ADDR_CTRL2) c2_r <= pwdata[7:0] & 8'h1B;
			if (wr && paddr == `SCM_ADDR_POWER) pw_r <= |pwdata[1:0];
			if (wr && paddr == `SCM_ADDR_POWER && pwdata[1]) begin
				c1_r <= 8'h04;
				c2_r <= 8'h00;
			end
			if (stop_wake_irq) pw_r <= 1'b0;
		end
	end
	a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error wrong");
	a_unmapped_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 0)
		else $error("unmapped read not zero");
	a_off_quiet: assert property (q_r == 2'd3 && !c1_r[6] |-> no_oe)
		else $error("pins driven while disabled");
	a_stop_quiet: assert property (pw_r && q_r == 2'd3 |-> no_oe [*2])
		else $error("pins driven in stop");
	a_tx_irq: assert property (q_r == 2'd3 && !pw_r && !c1_r[6] && c1_r[5] |-> irq)
		else $error("no transmit interrupt");
	a_irq_masked: assert property (q_r == 2'd3 && !c1_r[7] && !c1_r[5] |-> !irq)
		else $error("interrupt while masked");
	a_gpio_master: assert property (ok && c1_r[4] && !c2_r[4] |-> sel_pin_is_gpio && !sel_oe)
		else $error("select pin not released");
	a_slave_pin: assert property (ok && !c1_r[4] |-> !sel_pin_is_gpio && !sel_oe)
		else $error("slave select misused");
	a_fault_pin: assert property (ok && c1_r[4] && c2_r[4] && !c1_r[1] |-> !sel_pin_is_gpio && !sel_oe)
		else $error("fault input misused");
	a_auto_sel: assert property (ok && c1_r[4] && c2_r[4] && c1_r[1] |-> ##[0:2] sel_oe)
		else $error("select output not driven");
endmodule
bind scm_ctrl scm_ctrl_asserts chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .stop_wake_irq, .sclk_oe, .mosi_oe, .miso_oe, .sel_oe, .irq,
	.sel_pin_is_gpio);

// >>> tb/scm_far_slave.sv
`timescale 1ns/1ps
module scm_far_slave (
	// pins
	input  logic       sclk,
	input  logic       sel_n,
	input  logic       mosi,
	output logic       miso,
	// mode and data
	input  logic       clock_polarity,
	input  logic       cphase,
	input  logic [7:0] tx,
	output logic [7:0] cap
);
	logic [8:0] sh;
	wire lead = sclk ^ clock_polarity;
	// deselected output flips so stale data never passes for real
	assign miso = sel_n ? ~sh[8] : sh[8];
	always @(negedge sel_n) sh = cphase ? {1'b0, tx} : {tx, 1'b0};
	// sample on one edge, shift on the other
	always @(lead) begin
		if (!sel_n) begin
			if (lead ^ cphase) cap = {cap[6:0], mosi};
			else sh = {sh[7:0], 1'b0};
		end
	end
endmodule

// >>> tb/spi_control_and_low_power_modes_tb_top.sv
`timescale 1ns/1ps
`include "scm_consts.vh"
module spi_control_and_low_power_modes_tb_top;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, wake = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic sel_drv = 1, clock_polarity = 0, cph = 0, lsb = 0, e;
	logic [7:0] q, ptx = 0, d;
	wire [31:0] prdata;
	wire pready, pslverr, so, soe, mo, moe, io, ioe, lo, loe, irq, gpio, miso_p, sclk_w, sel_w;
	wire [7:0] cap;
	int fail_count = 0, checked = 0, k;
	assign sclk_w = soe ? so : 1'b0;
	assign sel_w = loe ? lo : sel_drv; // pulled up when nobody drives
	scm_ctrl uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.stop_wake_irq(wake), .sclk_in(sclk_w), .sclk_out(so), .sclk_oe(soe),
		.mosi_in(moe ? mo : 1'b0), .mosi_out(mo), .mosi_oe(moe),
		.miso_in(ioe ? io : miso_p), .miso_out(io), .miso_oe(ioe),
		.sel_in(sel_w), .sel_out(lo), .sel_oe(loe), .irq(irq), .sel_pin_is_gpio(gpio));
	scm_far_slave far (.sclk(sclk_w), .sel_n(sel_w), .mosi(mo), .miso(miso_p), .clock_polarity(clock_polarity),
		.cphase(cph), .tx(ptx), .cap(cap));
	always #25 clk = ~clk;
	function automatic [7:0] rv(input [7:0] x);
		for (int i = 0; i < 8; i++) rv[i] = x[7 - i];
	endfunction
	// one apb transfer; held until pready is seen high
	task xfer(input logic w, input [11:0] a, input [7:0] dv);
		@(posedge clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, dv};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 0; penable <= 0; pwrite <= 0;
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] a, input [7:0] dv); xfer(1, a, dv); endtask
	task rc(input [11:0] a, input [7:0] exp); xfer(0, a, 0); chk(q, exp); endtask
	task pulse_wake; @(posedge clk); wake <= 1; @(posedge clk); wake <= 0; endtask
	task conclude;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#1_000_000;
		fail_count++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1;
		rc(`SCM_ADDR_CTRL1, 8'h04);
		rc(`SCM_ADDR_STATUS, 8'h20);
		wr(`SCM_ADDR_CTRL2, 8'hFF); rc(`SCM_ADDR_CTRL2, 8'h1B);
		wr(`SCM_ADDR_BAUD, 8'hFF); rc(`SCM_ADDR_BAUD, 8'h77);
		wr(`SCM_ADDR_BAUD, 8'h21); // six-clock half bit covers the three-flop return path
		xfer(0, 12'h018, 0); chk({e, q[6:0]}, 8'h80);
		wr(`SCM_ADDR_CTRL1, 8'h20); @(posedge clk); chk(irq, 1);
		wr(`SCM_ADDR_CTRL1, 8'h80); @(posedge clk); chk(irq, 0);
		$display("test registers done");
		// every polarity, phase and order with automatic select
		wr(`SCM_ADDR_CTRL2, 8'h10);
		for (int m = 0; m < 8; m++) begin
			{clock_polarity, cph, lsb} = m[2:0];
			ptx = 8'h3A + m;
			d = 8'hC1 + 8'h11 * m;
			wr(`SCM_ADDR_CTRL1, {4'h5, clock_polarity, cph, 1'b1, lsb});
			@(posedge clk); @(negedge clk); chk(so, clock_polarity);
			wr(`SCM_ADDR_DATA, d);
			for (k = 0; k < 60; k++) begin xfer(0, `SCM_ADDR_STATUS, 0); if (q[7]) break; end
			chk(q[7], 1);
			rc(`SCM_ADDR_DATA, lsb ? rv(ptx) : ptx);
			chk(cap, lsb ? rv(d) : d);
		end
		$display("test transfers done");
		wr(`SCM_ADDR_DATA, 8'h55); repeat (3) @(posedge clk);
		wr(`SCM_ADDR_CTRL1, 8'h1F); rc(`SCM_ADDR_STATUS, 8'h20);
		wr(`SCM_ADDR_CTRL1, 8'hD0); sel_drv <= 0; repeat (6) @(posedge clk);
		chk(irq, 1);
		rc(`SCM_ADDR_STATUS, 8'h30);
		rc(`SCM_ADDR_CTRL1, 8'hC0);
		sel_drv <= 1;
		$display("test abort and fault done");
		wr(`SCM_ADDR_CTRL1, 8'h52); wr(`SCM_ADDR_POWER, 8'h01); repeat (2) @(posedge clk);
		chk({soe, loe, moe}, 0);
		pulse_wake; rc(`SCM_ADDR_CTRL1, 8'h52);
		wr(`SCM_ADDR_POWER, 8'h02); pulse_wake;
		rc(`SCM_ADDR_CTRL1, 8'h04); rc(`SCM_ADDR_CTRL2, 8'h00);
		wr(`SCM_ADDR_CTRL1, 8'h40); @(posedge clk); chk(gpio, 0);
		wr(`SCM_ADDR_CTRL1, 8'h50); @(posedge clk); chk(gpio, 1);
		$display("test stop and pin done");
		conclude;
	end
endmodule
